// [dacc_pkg.sv]
`default_nettype none
package dacc_pkg;
    localparam logic [15:0] DACC_OFS_CODE0 = 16'hFFF8;
    localparam logic [15:0] DACC_OFS_CODE1 = 16'hFFF9;
    localparam logic [15:0] DACC_OFS_CTRL = 16'hFFFA;
    localparam logic [7:0] DACC_CODE_RST = 8'h00;
    localparam logic [7:0] DACC_CTRL_RST = 8'h1F;
    localparam logic [7:0] DACC_CTRL_RSVD = 8'h1F;
    localparam logic [7:0] DACC_UNMAPPED = 8'h00;
    localparam int DACC_BIT_OE1 = 7;
    localparam int DACC_BIT_OE0 = 6;
    localparam int DACC_BIT_JOINT = 5;

    typedef struct packed {
        logic [7:0] code;
        logic conv_en;
        logic pin_oe_n;
    } dacc_chan_s;
endpackage
`default_nettype wire

// [dacc_conv_logic.sv]
`timescale 1ns/1ps
`default_nettype none
module dacc_conv_logic
    import dacc_pkg::*;
(
    // Enable bits
    input wire logic i_out_en_ch0,
    input wire logic i_out_en_ch1,
    input wire logic i_joint_conv_en,
    // Conversion enables
    output logic o_conv_ch0,
    output logic o_conv_ch1
);
    // Joint mode lets either enable wake both channels
    always_comb
    begin
        o_conv_ch0 = i_out_en_ch0 | (i_joint_conv_en & i_out_en_ch1);
        o_conv_ch1 = i_out_en_ch1 | (i_joint_conv_en & i_out_en_ch0);
    end
endmodule
`default_nettype wire

// [dacc_top.sv]
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module dacc_top
    import dacc_pkg::*;
(
    // Clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    // Standby entry level
    input wire logic I_STANDBY,
    // Register port
    input wire logic [15:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    // Converter side
    output dacc_chan_s O_CH0,
    output dacc_chan_s O_CH1
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] code_reg_ch0_q;
    logic [7:0] code_reg_ch1_q;
    logic out_en_ch0_q;
    logic out_en_ch1_q;
    logic joint_conv_en_q;
    logic conv_ch0;
    logic conv_ch1;
    logic [7:0] ctrl_rd;

    // Full 16-bit compare, so no register shows up at an alias
    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        hit = (a == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Standby is treated as a synchronous clear from same-clock logic
    always_ff @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            code_reg_ch0_q <= DACC_CODE_RST;
            code_reg_ch1_q <= DACC_CODE_RST;
        end
        else if (I_STANDBY)
        begin
            code_reg_ch0_q <= DACC_CODE_RST;
            code_reg_ch1_q <= DACC_CODE_RST;
        end
        else if (I_WR)
        begin
            if (hit(I_ADDR, DACC_OFS_CODE0))
                code_reg_ch0_q <= I_WDATA;
            if (hit(I_ADDR, DACC_OFS_CODE1))
                code_reg_ch1_q <= I_WDATA;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            out_en_ch1_q <= DACC_CTRL_RST[DACC_BIT_OE1];
            out_en_ch0_q <= DACC_CTRL_RST[DACC_BIT_OE0];
            joint_conv_en_q <= DACC_CTRL_RST[DACC_BIT_JOINT];
        end
        else if (I_STANDBY)
        begin
            out_en_ch1_q <= DACC_CTRL_RST[DACC_BIT_OE1];
            out_en_ch0_q <= DACC_CTRL_RST[DACC_BIT_OE0];
            joint_conv_en_q <= DACC_CTRL_RST[DACC_BIT_JOINT];
        end
        else if (I_WR && hit(I_ADDR, DACC_OFS_CTRL))
        begin
            // Low five bits have no storage at all
            out_en_ch1_q <= I_WDATA[DACC_BIT_OE1];
            out_en_ch0_q <= I_WDATA[DACC_BIT_OE0];
            joint_conv_en_q <= I_WDATA[DACC_BIT_JOINT];
        end
    end

    dacc_conv_logic u_conv
    (
        .i_out_en_ch0(out_en_ch0_q),
        .i_out_en_ch1(out_en_ch1_q),
        .i_joint_conv_en(joint_conv_en_q),
        .o_conv_ch0(conv_ch0),
        .o_conv_ch1(conv_ch1)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs registered from the stored state, so they lag a write by one cycle
    always_ff @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            O_CH0 <= '{code: DACC_CODE_RST, conv_en: 1'b0, pin_oe_n: 1'b1};
            O_CH1 <= '{code: DACC_CODE_RST, conv_en: 1'b0, pin_oe_n: 1'b1};
        end
        else
        begin
            O_CH0.code <= code_reg_ch0_q;
            O_CH1.code <= code_reg_ch1_q;
            O_CH0.conv_en <= conv_ch0;
            O_CH1.conv_en <= conv_ch1;
            O_CH0.pin_oe_n <= ~out_en_ch0_q;
            O_CH1.pin_oe_n <= ~out_en_ch1_q;
        end
    end

    // Reserved bits have no flops behind them; they read as ones
    always_comb
    begin
        ctrl_rd = DACC_CTRL_RSVD;
        ctrl_rd[DACC_BIT_OE1] = out_en_ch1_q;
        ctrl_rd[DACC_BIT_OE0] = out_en_ch0_q;
        ctrl_rd[DACC_BIT_JOINT] = joint_conv_en_q;
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
            O_RDATA <= DACC_UNMAPPED;
        else if (!I_RD)
            O_RDATA <= DACC_UNMAPPED;
        else if (hit(I_ADDR, DACC_OFS_CODE0))
            O_RDATA <= code_reg_ch0_q;
        else if (hit(I_ADDR, DACC_OFS_CODE1))
            O_RDATA <= code_reg_ch1_q;
        else if (hit(I_ADDR, DACC_OFS_CTRL))
            O_RDATA <= ctrl_rd;
        else
            O_RDATA <= DACC_UNMAPPED;
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_standby_clear;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        I_STANDBY |=> (code_reg_ch0_q == DACC_CODE_RST && code_reg_ch1_q == DACC_CODE_RST);
    endproperty
    a_standby_clear: assert property (p_standby_clear) else $error("codes not cleared");

    property p_standby_ctrl;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        I_STANDBY |=> (ctrl_rd == DACC_CTRL_RST);
    endproperty
    a_standby_ctrl: assert property (p_standby_ctrl) else $error("control not reset");

    property p_code_write;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (I_WR && !I_STANDBY && I_ADDR == DACC_OFS_CODE0) |=> ##1 (O_CH0.code == $past(I_WDATA, 2));
    endproperty
    a_code_write: assert property (p_code_write) else $error("ch0 code not presented");

    property p_code1_write;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (I_WR && !I_STANDBY && I_ADDR == DACC_OFS_CODE1) |=> (code_reg_ch1_q == $past(I_WDATA));
    endproperty
    a_code1_write: assert property (p_code1_write) else $error("ch1 code not stored");

    property p_oe1;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        out_en_ch1_q |=> (!O_CH1.pin_oe_n && O_CH1.conv_en);
    endproperty
    a_oe1: assert property (p_oe1) else $error("ch1 not enabled");

    property p_oe0;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        out_en_ch0_q |=> (!O_CH0.pin_oe_n && O_CH0.conv_en);
    endproperty
    a_oe0: assert property (p_oe0) else $error("ch0 not enabled");

    property p_joint;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (joint_conv_en_q && (out_en_ch0_q ^ out_en_ch1_q)) |=> (O_CH0.conv_en && O_CH1.conv_en);
    endproperty
    a_joint: assert property (p_joint) else $error("joint conversion missing");

    property p_both_off;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (!out_en_ch0_q && !out_en_ch1_q) |=> (!O_CH0.conv_en && !O_CH1.conv_en);
    endproperty
    a_both_off: assert property (p_both_off) else $error("conversion while disabled");

    property p_sep;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (!joint_conv_en_q && out_en_ch0_q && !out_en_ch1_q) |=> (!O_CH1.conv_en && O_CH1.pin_oe_n);
    endproperty
    a_sep: assert property (p_sep) else $error("separate mode leak");

    property p_rsvd;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (I_RD && I_ADDR == DACC_OFS_CTRL) |=> (O_RDATA[4:0] == 5'h1F);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not ones");

    property p_pin_off;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        !out_en_ch0_q |=> O_CH0.pin_oe_n;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("ch0 pin driven");

    property p_pin_off1;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        !out_en_ch1_q |=> O_CH1.pin_oe_n;
    endproperty
    a_pin_off1: assert property (p_pin_off1) else $error("ch1 pin driven");

    // Pin drive must not follow joint mode
    property p_pin_own0;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        1'b1 |=> (O_CH0.pin_oe_n == !$past(out_en_ch0_q));
    endproperty
    a_pin_own0: assert property (p_pin_own0) else $error("ch0 pin enable wrong");

    property p_pin_own1;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        1'b1 |=> (O_CH1.pin_oe_n == !$past(out_en_ch1_q));
    endproperty
    a_pin_own1: assert property (p_pin_own1) else $error("ch1 pin enable wrong");

    property p_sep1;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (!joint_conv_en_q && out_en_ch1_q && !out_en_ch0_q) |=> (!O_CH0.conv_en && O_CH0.pin_oe_n);
    endproperty
    a_sep1: assert property (p_sep1) else $error("separate mode leak on ch0");

    property p_both_on;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (out_en_ch0_q && out_en_ch1_q) |=> (O_CH0.conv_en && O_CH1.conv_en);
    endproperty
    a_both_on: assert property (p_both_on) else $error("both enabled without conversion");

    property p_off0_sep;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (!joint_conv_en_q && !out_en_ch0_q) |=> !O_CH0.conv_en;
    endproperty
    a_off0_sep: assert property (p_off0_sep) else $error("ch0 converts while off");

    property p_off1_sep;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (!joint_conv_en_q && !out_en_ch1_q) |=> !O_CH1.conv_en;
    endproperty
    a_off1_sep: assert property (p_off1_sep) else $error("ch1 converts while off");

    ////////////////////////////////////////////////////////////////////////////
    // Register port stores and read-back
    property p_code0_store;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (I_WR && !I_STANDBY && I_ADDR == DACC_OFS_CODE0) |=> (code_reg_ch0_q == $past(I_WDATA));
    endproperty
    a_code0_store: assert property (p_code0_store) else $error("ch0 code not stored");

    property p_code1_out;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (I_WR && !I_STANDBY && I_ADDR == DACC_OFS_CODE1) |=> ##1 (O_CH1.code == $past(I_WDATA, 2));
    endproperty
    a_code1_out: assert property (p_code1_out) else $error("ch1 code not presented");

    property p_oe1_store;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (I_WR && !I_STANDBY && I_ADDR == DACC_OFS_CTRL) |=> (out_en_ch1_q == $past(I_WDATA[DACC_BIT_OE1]));
    endproperty
    a_oe1_store: assert property (p_oe1_store) else $error("ch1 enable not stored");

    property p_oe0_store;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (I_WR && !I_STANDBY && I_ADDR == DACC_OFS_CTRL) |=> (out_en_ch0_q == $past(I_WDATA[DACC_BIT_OE0]));
    endproperty
    a_oe0_store: assert property (p_oe0_store) else $error("ch0 enable not stored");

    property p_joint_store;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (I_WR && !I_STANDBY && I_ADDR == DACC_OFS_CTRL) |=> (joint_conv_en_q == $past(I_WDATA[DACC_BIT_JOINT]));
    endproperty
    a_joint_store: assert property (p_joint_store) else $error("joint enable not stored");

    property p_rd_code0;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (I_RD && I_ADDR == DACC_OFS_CODE0) |=> (O_RDATA == $past(code_reg_ch0_q));
    endproperty
    a_rd_code0: assert property (p_rd_code0) else $error("ch0 code read wrong");

    property p_rd_code1;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (I_RD && I_ADDR == DACC_OFS_CODE1) |=> (O_RDATA == $past(code_reg_ch1_q));
    endproperty
    a_rd_code1: assert property (p_rd_code1) else $error("ch1 code read wrong");

    property p_rd_ctrl;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (I_RD && I_ADDR == DACC_OFS_CTRL) |=> (O_RDATA[DACC_BIT_OE1] == $past(out_en_ch1_q)
            && O_RDATA[DACC_BIT_OE0] == $past(out_en_ch0_q)
            && O_RDATA[DACC_BIT_JOINT] == $past(joint_conv_en_q));
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");

    // Stored state moves only on a strobe or standby
    property p_code0_hold;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (!I_STANDBY && !(I_WR && I_ADDR == DACC_OFS_CODE0)) |=> $stable(code_reg_ch0_q);
    endproperty
    a_code0_hold: assert property (p_code0_hold) else $error("ch0 code changed unasked");

    property p_code1_hold;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (!I_STANDBY && !(I_WR && I_ADDR == DACC_OFS_CODE1)) |=> $stable(code_reg_ch1_q);
    endproperty
    a_code1_hold: assert property (p_code1_hold) else $error("ch1 code changed unasked");

    property p_ctrl_hold;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        (!I_STANDBY && !(I_WR && I_ADDR == DACC_OFS_CTRL)) |=> $stable(ctrl_rd);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed unasked");

    ////////////////////////////////////////////////////////////////////////////
    // Outputs trail the stored state by one edge
    property p_code_out0;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        1'b1 |=> (O_CH0.code == $past(code_reg_ch0_q));
    endproperty
    a_code_out0: assert property (p_code_out0) else $error("ch0 code lags wrongly");

    property p_code_out1;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        1'b1 |=> (O_CH1.code == $past(code_reg_ch1_q));
    endproperty
    a_code_out1: assert property (p_code_out1) else $error("ch1 code lags wrongly");

    // Standby returns both channels to idle
    property p_standby_out;
        @(posedge I_CORE_CLK) disable iff (!I_NRST)
        I_STANDBY |=> ##1 (O_CH0.code == DACC_CODE_RST && O_CH1.code == DACC_CODE_RST
            && !O_CH0.conv_en && !O_CH1.conv_en && O_CH0.pin_oe_n && O_CH1.pin_oe_n);
    endproperty
    a_standby_out: assert property (p_standby_out) else $error("outputs not idle after standby");

    // Main scenarios
    c_joint: cover property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
        joint_conv_en_q && out_en_ch1_q && !out_en_ch0_q);
    c_both: cover property (@(posedge I_CORE_CLK) disable iff (!I_NRST) out_en_ch0_q && out_en_ch1_q);
    c_standby: cover property (@(posedge I_CORE_CLK) disable iff (!I_NRST) out_en_ch0_q ##1 I_STANDBY);
    c_sep: cover property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
        !joint_conv_en_q && out_en_ch0_q && !out_en_ch1_q);
    c_code_write: cover property (@(posedge I_CORE_CLK) disable iff (!I_NRST)
        I_WR && I_ADDR == DACC_OFS_CODE1);
endmodule
`default_nettype wire

// [test_dual_dac_control_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module test_dual_dac_control_regs;
    import dacc_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic standby = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    dacc_chan_s ch0;
    dacc_chan_s ch1;
    int err_total = 0;
    int checked = 0;

    dacc_top dacc_top_inst (.I_CORE_CLK(core_clk), .I_NRST(nrst), .I_STANDBY(standby), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_CH0(ch0), .O_CH1(ch1));

    always #4 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (err_total == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp_data(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_chan(input string what, input dacc_chan_s exp, input dacc_chan_s got);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask

    // Read data is looked at only in the cycle after the strobe
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        cmp_data("read data", exp, rdata);
    endtask

    // Outputs land one edge after the write is stored
    task automatic out_chk(input dacc_chan_s e0, input dacc_chan_s e1);
        @(posedge core_clk);
        #1;
        cmp_chan("channel 0", e0, ch0);
        cmp_chan("channel 1", e1, ch1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        out_chk('{8'h00, 1'b0, 1'b1}, '{8'h00, 1'b0, 1'b1});
        rd_chk(DACC_OFS_CODE0, 8'h00);
        rd_chk(DACC_OFS_CODE1, 8'h00);
        rd_chk(DACC_OFS_CTRL, 8'h1F);
    endtask

    task automatic t_codes();
        wr_reg(DACC_OFS_CODE0, 8'hA5);
        wr_reg(DACC_OFS_CODE1, 8'h5A);
        out_chk('{8'hA5, 1'b0, 1'b1}, '{8'h5A, 1'b0, 1'b1});
        rd_chk(DACC_OFS_CODE0, 8'hA5);
        rd_chk(DACC_OFS_CODE1, 8'h5A);
        wr_reg(16'hFFFB, 8'h33);
        rd_chk(16'hFFFB, 8'h00);
        rd_chk(DACC_OFS_CODE1, 8'h5A);
    endtask

    // Every combination of the three enable bits, reserved bits written as zero
    task automatic t_enables();
        logic o1;
        logic o0;
        logic j;
        dacc_chan_s e0;
        dacc_chan_s e1;
        for (int i = 0; i < 8; i++)
        begin
            {o1, o0, j} = i[2:0];
            wr_reg(DACC_OFS_CTRL, {o1, o0, j, 5'h00});
            e0 = '{8'hA5, j ? (o0 | o1) : o0, ~o0};
            e1 = '{8'h5A, j ? (o0 | o1) : o1, ~o1};
            out_chk(e0, e1);
            rd_chk(DACC_OFS_CTRL, {o1, o0, j, 5'h1F});
        end
    endtask

    // Standby wins over a write in the same cycle
    task automatic t_standby();
        wr_reg(DACC_OFS_CTRL, 8'hE0);
        @(posedge core_clk);
        standby <= 1'b1;
        addr <= DACC_OFS_CODE0;
        wdata <= 8'h77;
        wr <= 1'b1;
        @(posedge core_clk);
        standby <= 1'b0;
        wr <= 1'b0;
        out_chk('{8'h00, 1'b0, 1'b1}, '{8'h00, 1'b0, 1'b1});
        rd_chk(DACC_OFS_CODE0, 8'h00);
        rd_chk(DACC_OFS_CTRL, 8'h1F);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_codes();
        t_enables();
        t_standby();
        stop_test();
    end

    // Whole run needs fewer than a hundred cycles
    initial
    begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire
